// ===== hw/conv_status_pkg.sv
/*
 * constants for the converter status and result register bank:
 * register addresses, flag positions, mode codes and reset values.
 * assumes an 8-bit special-function-register space on the core clock.
 */
package conv_status_pkg;
   // register addresses
   localparam logic [7:0] ADDR_STATUS = 8'hD8;
   localparam logic [7:0] ADDR_MODE = 8'hD1;
   localparam logic [7:0] ADDR_DECIM = 8'hD4;
   localparam logic [7:0] ADDR_PRES_L = 8'hD9;
   localparam logic [7:0] ADDR_PRES_M = 8'hDA;
   localparam logic [7:0] ADDR_PRES_H = 8'hDB;
   localparam logic [7:0] ADDR_ARES_L = 8'hDC;
   localparam logic [7:0] ADDR_ARES_H = 8'hDD;
   localparam logic [7:0] ADDR_POFS_L = 8'hE1;
   localparam logic [7:0] ADDR_POFS_M = 8'hE2;
   localparam logic [7:0] ADDR_POFS_H = 8'hE3;
   localparam logic [7:0] ADDR_AOFS_L = 8'hE4;
   localparam logic [7:0] ADDR_AOFS_H = 8'hE5;
   localparam logic [7:0] ADDR_PGAIN_L = 8'hE9;
   localparam logic [7:0] ADDR_PGAIN_M = 8'hEA;
   localparam logic [7:0] ADDR_PGAIN_H = 8'hEB;
   localparam logic [7:0] ADDR_AGAIN_L = 8'hEC;
   localparam logic [7:0] ADDR_AGAIN_H = 8'hED;
   // status flag positions
   localparam int BIT_RDY_P = 7;
   localparam int BIT_RDY_A = 6;
   localparam int BIT_CAL = 5;
   localparam int BIT_NOREF = 4;
   localparam int BIT_ERR_P = 3;
   localparam int BIT_ERR_A = 2;
   // mode register fields
   localparam int BIT_EN_P = 5;
   localparam int BIT_EN_A = 4;
   localparam logic [7:0] MODE_WMASK = 8'h37;
   // mode select codes
   localparam logic [2:0] MD_OFF = 3'h0;
   localparam logic [2:0] MD_IDLE = 3'h1;
   localparam logic [2:0] MD_SINGLE = 3'h2;
   localparam logic [2:0] MD_CONT = 3'h3;
   localparam logic [2:0] MD_ZCAL = 3'h4;
   localparam logic [2:0] MD_FCAL = 3'h5;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] DECIM_RST = 8'h40;
   localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

// ===== hw/conv_status_regs.sv
/*
 * status, result and coefficient registers for a primary (24-bit)
 * and an auxiliary (16-bit) sigma-delta converter.
 * assumes the converters pulse a done strobe with their data for one
 * cycle, and that the core issues byte and bit accesses synchronously.
 */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// Contract
// - primary ready flag, status bit 7, sets when conversion or calibration ends
// - primary ready clears on software zero write or a starting mode write
// - while primary ready is set, the primary converter cannot update results or coefficients; software coefficient writes still apply
// - bit 6 is the auxiliary ready flag with the same behaviour
// - trim-done flag, bit 5, sets when a calibration ends
// - trim-done clears only by a mode write that starts work
// - missing-reference flag, bit 4, tracks the reference only while active
// - missing reference with external reference selected forces results to ones
// - primary error flag, bit 3, sets when the written result was clamped
// - primary error flag also sets when a calibration failed to update coefficients
// - primary error flag clears when software starts a conversion or calibration
// - bit 2 is the auxiliary error flag with the same behaviour
// - primary result is 24 bits in low, middle and high bytes
// - auxiliary result is 16 bits in low and high bytes
// - offset coefficients: 24 bits primary, 16 bits auxiliary, in bytes
// - gain coefficients: 24 bits primary, 16 bits auxiliary, in bytes
// - status register at D8H, resets to 00H, bit addressable, bits 1:0 reserved
// - decimation ratio register sets the filter decimation and update rate
// - single conversion updates results, flags, then writes mode select to 000
// - mode 100 starts zero-scale calibration, 101 full-scale calibration
module conv_status_regs
   import conv_status_pkg::*;
#(
   parameter int PW = 24,
   parameter int AW = 16
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_bit_wr,
   input wire logic [7:0] i_bit_addr,
   input wire logic i_bit_val,
   input wire logic i_pri_done,
   input wire logic [PW-1:0] i_pri_data,
   input wire logic i_pri_clamp,
   input wire logic i_pri_cal_err,
   input wire logic i_aux_done,
   input wire logic [AW-1:0] i_aux_data,
   input wire logic i_aux_clamp,
   input wire logic i_aux_cal_err,
   input wire logic i_ref_bad,
   input wire logic i_ext_ref_sel,
   output logic [7:0] o_sfr_rdata,
   output logic [7:0] o_mode,
   output logic [7:0] o_decim_ratio
);
   //////////////////////////////////////////////////////////////////
   // decoding helpers
   function automatic logic is_run(input logic [2:0] md);
      is_run = (md == MD_SINGLE) || (md == MD_CONT) ||
               (md == MD_ZCAL) || (md == MD_FCAL);
   endfunction

   function automatic logic is_cal(input logic [2:0] md);
      is_cal = (md == MD_ZCAL) || (md == MD_FCAL);
   endfunction

   // byte n of a wide value
   function automatic logic [7:0] byte_of(input logic [23:0] v, input int n);
      byte_of = v[n*8 +: 8];
   endfunction

   //////////////////////////////////////////////////////////////////
   // state
   logic [7:0] status_q, status_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] decim_q, decim_d;
   logic [23:0] pres_q, pres_d;
   logic [23:0] pofs_q, pofs_d;
   logic [23:0] pgain_q, pgain_d;
   logic [AW-1:0] ares_q, ares_d;
   logic [AW-1:0] aofs_q, aofs_d;
   logic [AW-1:0] again_q, again_d;
   logic [7:0] rdata_q, rdata_d;
   logic [23:0] pri_val, aux_val;
   logic wr_mode, start, start_p, start_a;
   logic active, force_ones, pri_take, aux_take;
   logic stat_bwr;

   //////////////////////////////////////////////////////////////////
   // event decode
   always_comb begin
      wr_mode = i_sfr_wr && (i_sfr_addr == ADDR_MODE);
      start = wr_mode && is_run(i_sfr_wdata[2:0]);
      start_p = start && i_sfr_wdata[BIT_EN_P];
      start_a = start && i_sfr_wdata[BIT_EN_A];
      active = (mode_q[BIT_EN_P] || mode_q[BIT_EN_A]) && is_run(mode_q[2:0]);
      force_ones = status_q[BIT_NOREF] && i_ext_ref_sel;
      pri_take = i_pri_done && !status_q[BIT_RDY_P];
      aux_take = i_aux_done && !status_q[BIT_RDY_A];
      stat_bwr = i_bit_wr && (i_bit_addr[7:3] == ADDR_STATUS[7:3]);
      pri_val = 24'h000000;
      aux_val = 24'h000000;
      pri_val[PW-1:0] = force_ones ? {PW{1'b1}} : i_pri_data;
      aux_val[AW-1:0] = force_ones ? {AW{1'b1}} : i_aux_data;
   end

   //////////////////////////////////////////////////////////////////
   // next-state of flags, mode and data registers
   always_comb begin
      status_d = status_q;
      mode_d = mode_q;
      decim_d = decim_q;
      pres_d = pres_q;
      pofs_d = pofs_q;
      pgain_d = pgain_q;
      ares_d = ares_q;
      aofs_d = aofs_q;
      again_d = again_q;
      // software clears come first so hardware sets win
      if (i_sfr_wr && (i_sfr_addr == ADDR_STATUS)) begin
         status_d[BIT_RDY_P] = status_q[BIT_RDY_P] & i_sfr_wdata[BIT_RDY_P];
         status_d[BIT_RDY_A] = status_q[BIT_RDY_A] & i_sfr_wdata[BIT_RDY_A];
      end
      if (stat_bwr && !i_bit_val) begin
         if (i_bit_addr[2:0] == 3'(BIT_RDY_P)) begin
            status_d[BIT_RDY_P] = 1'b0;
         end
         if (i_bit_addr[2:0] == 3'(BIT_RDY_A)) begin
            status_d[BIT_RDY_A] = 1'b0;
         end
      end
      if (start) begin
         status_d[BIT_CAL] = 1'b0;
      end
      if (start_p) begin
         status_d[BIT_RDY_P] = 1'b0;
         status_d[BIT_ERR_P] = 1'b0;
      end
      if (start_a) begin
         status_d[BIT_RDY_A] = 1'b0;
         status_d[BIT_ERR_A] = 1'b0;
      end
      // reference detect only while a converter runs
      if (active) begin
         status_d[BIT_NOREF] = i_ref_bad;
      end
      // primary completion
      if (pri_take) begin
         status_d[BIT_RDY_P] = 1'b1;
         if (is_cal(mode_q[2:0])) begin
            status_d[BIT_CAL] = 1'b1;
            if (i_pri_cal_err) begin
               status_d[BIT_ERR_P] = 1'b1;
            end else if (mode_q[2:0] == MD_ZCAL) begin
               pofs_d = pri_val;
            end else begin
               pgain_d = pri_val;
            end
         end else begin
            pres_d = pri_val;
            if (i_pri_clamp || force_ones) begin
               status_d[BIT_ERR_P] = 1'b1;
            end
         end
      end
      // auxiliary completion
      if (aux_take) begin
         status_d[BIT_RDY_A] = 1'b1;
         if (is_cal(mode_q[2:0])) begin
            status_d[BIT_CAL] = 1'b1;
            if (i_aux_cal_err) begin
               status_d[BIT_ERR_A] = 1'b1;
            end else if (mode_q[2:0] == MD_ZCAL) begin
               aofs_d = aux_val[AW-1:0];
            end else begin
               again_d = aux_val[AW-1:0];
            end
         end else begin
            ares_d = aux_val[AW-1:0];
            if (i_aux_clamp || force_ones) begin
               status_d[BIT_ERR_A] = 1'b1;
            end
         end
      end
      // single conversion drops back to power-down
      if ((pri_take || aux_take) && (mode_q[2:0] == MD_SINGLE)) begin
         mode_d[2:0] = MD_OFF;
      end
      status_d[1:0] = 2'b00;
      // software byte writes to control and coefficients
      if (i_sfr_wr) begin
         case (i_sfr_addr)
            ADDR_MODE: mode_d = i_sfr_wdata & MODE_WMASK;
            ADDR_DECIM: decim_d = i_sfr_wdata;
            ADDR_POFS_L: pofs_d[7:0] = i_sfr_wdata;
            ADDR_POFS_M: pofs_d[15:8] = i_sfr_wdata;
            ADDR_POFS_H: pofs_d[23:16] = i_sfr_wdata;
            ADDR_PGAIN_L: pgain_d[7:0] = i_sfr_wdata;
            ADDR_PGAIN_M: pgain_d[15:8] = i_sfr_wdata;
            ADDR_PGAIN_H: pgain_d[23:16] = i_sfr_wdata;
            ADDR_AOFS_L: aofs_d[7:0] = i_sfr_wdata;
            ADDR_AOFS_H: aofs_d[15:8] = i_sfr_wdata;
            ADDR_AGAIN_L: again_d[7:0] = i_sfr_wdata;
            ADDR_AGAIN_H: again_d[15:8] = i_sfr_wdata;
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_q <= STATUS_RST;
         mode_q <= MODE_RST;
         decim_q <= DECIM_RST;
         pres_q <= 24'h000000;
         pofs_q <= 24'h000000;
         pgain_q <= 24'h000000;
         ares_q <= '0;
         aofs_q <= '0;
         again_q <= '0;
      end else if (i_ce) begin
         status_q <= status_d;
         mode_q <= mode_d;
         decim_q <= decim_d;
         pres_q <= pres_d;
         pofs_q <= pofs_d;
         pgain_q <= pgain_d;
         ares_q <= ares_d;
         aofs_q <= aofs_d;
         again_q <= again_d;
      end
   end

   //////////////////////////////////////////////////////////////////
   // read data, captured on a read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            ADDR_STATUS: rdata_d = status_q & 8'hFC;
            ADDR_MODE: rdata_d = mode_q;
            ADDR_DECIM: rdata_d = decim_q;
            ADDR_PRES_L: rdata_d = byte_of(pres_q, 0);
            ADDR_PRES_M: rdata_d = byte_of(pres_q, 1);
            ADDR_PRES_H: rdata_d = byte_of(pres_q, 2);
            ADDR_ARES_L: rdata_d = byte_of(24'(ares_q), 0);
            ADDR_ARES_H: rdata_d = byte_of(24'(ares_q), 1);
            ADDR_POFS_L: rdata_d = byte_of(pofs_q, 0);
            ADDR_POFS_M: rdata_d = byte_of(pofs_q, 1);
            ADDR_POFS_H: rdata_d = byte_of(pofs_q, 2);
            ADDR_AOFS_L: rdata_d = byte_of(24'(aofs_q), 0);
            ADDR_AOFS_H: rdata_d = byte_of(24'(aofs_q), 1);
            ADDR_PGAIN_L: rdata_d = byte_of(pgain_q, 0);
            ADDR_PGAIN_M: rdata_d = byte_of(pgain_q, 1);
            ADDR_PGAIN_H: rdata_d = byte_of(pgain_q, 2);
            ADDR_AGAIN_L: rdata_d = byte_of(24'(again_q), 0);
            ADDR_AGAIN_H: rdata_d = byte_of(24'(again_q), 1);
            default: rdata_d = RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= RDATA_RST;
      end else if (i_ce) begin
         rdata_q <= rdata_d;
      end
   end

   // outputs straight from flops
   assign o_sfr_rdata = rdata_q;
   assign o_mode = mode_q;
   assign o_decim_ratio = decim_q;

   //////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   AST_RDY_P_SET: assert property (
      i_ce && i_pri_done && !status_q[BIT_RDY_P] |=> status_q[BIT_RDY_P])
      else $error("primary ready not set after done");

   AST_RDY_P_CLR: assert property (
      i_ce && start_p && !i_pri_done |=> !status_q[BIT_RDY_P])
      else $error("primary ready not cleared by start");

   AST_P_BLOCK: assert property (
      i_ce && status_q[BIT_RDY_P] && !i_sfr_wr |=>
      $stable(pres_q) && $stable(pofs_q) && $stable(pgain_q))
      else $error("primary data changed while ready set");

   AST_RDY_A_SET: assert property (
      i_ce && i_aux_done && !status_q[BIT_RDY_A] |=> status_q[BIT_RDY_A])
      else $error("auxiliary ready not set after done");

   AST_CAL_SET: assert property (
      i_ce && pri_take && is_cal(mode_q[2:0]) |=> status_q[BIT_CAL])
      else $error("trim-done not set after calibration");

   AST_CAL_HOLD: assert property (
      status_q[BIT_CAL] && !(i_ce && start) |=> status_q[BIT_CAL])
      else $error("trim-done cleared without start");

   AST_FORCE_ONES: assert property (
      i_ce && pri_take && force_ones && !is_cal(mode_q[2:0]) |=>
      pres_q[PW-1:0] == {PW{1'b1}} && status_q[BIT_ERR_P])
      else $error("missing reference did not force ones");

   AST_ERR_P_SET: assert property (
      i_ce && pri_take && i_pri_clamp && !is_cal(mode_q[2:0]) |=>
      status_q[BIT_ERR_P])
      else $error("primary error not set on clamp");

   AST_SINGLE_OFF: assert property (
      i_ce && pri_take && mode_q[2:0] == MD_SINGLE && !wr_mode |=>
      mode_q[2:0] == MD_OFF)
      else $error("single conversion did not return to power-down");

   AST_RSVD_ZERO: assert property (
      status_q[1:0] == 2'b00)
      else $error("reserved status bits not zero");
endmodule // conv_status_regs

// ===== sim/dual_adc_status_flag_logic_tb_top.sv
/*
 * self-checking bench for the converter status and result register bank.
 * assumes conv_status_pkg and conv_status_regs are compiled first; the bench
 * plays both the core's register accesses and the converters' done strobes.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module dual_adc_status_flag_logic_tb_top;
   import conv_status_pkg::*;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_ce = 1'b1;
   logic i_sfr_wr = 1'b0;
   logic i_sfr_rd = 1'b0;
   logic [7:0] i_sfr_addr = 8'h00;
   logic [7:0] i_sfr_wdata = 8'h00;
   logic i_bit_wr = 1'b0;
   logic [7:0] i_bit_addr = 8'h00;
   logic i_bit_val = 1'b0;
   logic i_pri_done = 1'b0;
   logic [23:0] i_pri_data = 24'h000000;
   logic i_pri_clamp = 1'b0;
   logic i_pri_cal_err = 1'b0;
   logic i_aux_done = 1'b0;
   logic [15:0] i_aux_data = 16'h0000;
   logic i_aux_clamp = 1'b0;
   logic i_aux_cal_err = 1'b0;
   logic i_ref_bad = 1'b0;
   logic i_ext_ref_sel = 1'b0;
   logic [7:0] o_sfr_rdata;
   logic [7:0] o_mode;
   logic [7:0] o_decim_ratio;
   int bad_count = 0;
   int checks_done = 0;
   // reset-value rows: address in the upper byte, expected read in the lower
   logic [15:0] rows [9] = '{16'hD800, 16'hD100, 16'hD440, 16'hD900, 16'hDD00,
                             16'hE100, 16'hED00, 16'hEB00, 16'h0000};

   always #5 i_clk = ~i_clk;

   conv_status_regs dut_u (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_sfr_wr(i_sfr_wr),
      .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
      .i_bit_wr(i_bit_wr), .i_bit_addr(i_bit_addr), .i_bit_val(i_bit_val),
      .i_pri_done(i_pri_done), .i_pri_data(i_pri_data), .i_pri_clamp(i_pri_clamp),
      .i_pri_cal_err(i_pri_cal_err), .i_aux_done(i_aux_done), .i_aux_data(i_aux_data),
      .i_aux_clamp(i_aux_clamp), .i_aux_cal_err(i_aux_cal_err), .i_ref_bad(i_ref_bad),
      .i_ext_ref_sel(i_ext_ref_sel), .o_sfr_rdata(o_sfr_rdata), .o_mode(o_mode),
      .o_decim_ratio(o_decim_ratio)
   );

   //////////////////////////////////////////////////////////////////////
   // access tasks, all driving on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_sfr_wr = 1'b1;
      i_sfr_addr = a;
      i_sfr_wdata = d;
      @(negedge i_clk);
      i_sfr_wr = 1'b0;
   endtask

   task automatic bw(input logic [7:0] a, input logic v);
      @(negedge i_clk);
      i_bit_wr = 1'b1;
      i_bit_addr = a;
      i_bit_val = v;
      @(negedge i_clk);
      i_bit_wr = 1'b0;
   endtask

   // read takes one edge, data then stands until the next read
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clk);
      i_sfr_rd = 1'b1;
      i_sfr_addr = a;
      @(negedge i_clk);
      i_sfr_rd = 1'b0;
      @(negedge i_clk);
      `CHK($sformatf("reg %h", a), e, o_sfr_rdata)
   endtask

   // one-cycle converter done strobe with its qualifiers
   task automatic pulse(input logic p, input logic [23:0] d, input logic cl, input logic ce);
      @(negedge i_clk);
      if (p) begin
         i_pri_done = 1'b1;
         i_pri_data = d;
         i_pri_clamp = cl;
         i_pri_cal_err = ce;
      end else begin
         i_aux_done = 1'b1;
         i_aux_data = d[15:0];
         i_aux_clamp = cl;
         i_aux_cal_err = ce;
      end
      @(negedge i_clk);
      {i_pri_done, i_pri_clamp, i_pri_cal_err} = 3'h0;
      {i_aux_done, i_aux_clamp, i_aux_cal_err} = 3'h0;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////
   // watchdog well past the expected few hundred cycles
   initial begin
      #200000;
      bad_count++;
      final_report();
   end

   //////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(negedge i_clk);
      i_resetn = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rchk(rows[i][15:8], rows[i][7:0]);
      end
      // status writes of ones and reserved bits change nothing
      wr(ADDR_STATUS, 8'hFF);
      rchk(ADDR_STATUS, 8'h00);
      // single conversion on the primary converter
      wr(ADDR_MODE, 8'h22);
      pulse(1'b1, 24'h123456, 1'b0, 1'b0);
      `CHK("mode", 8'h20, o_mode)
      rchk(ADDR_STATUS, 8'h80);
      rchk(ADDR_PRES_L, 8'h56);
      rchk(ADDR_PRES_M, 8'h34);
      rchk(ADDR_PRES_H, 8'h12);
      // a second done while ready is set is dropped
      pulse(1'b1, 24'h654321, 1'b1, 1'b0);
      rchk(ADDR_PRES_L, 8'h56);
      rchk(ADDR_STATUS, 8'h80);
      // bit write of zero clears ready, then a clamped result flags an error
      bw(8'hDF, 1'b0);
      rchk(ADDR_STATUS, 8'h00);
      pulse(1'b1, 24'hFFFFFF, 1'b1, 1'b0);
      rchk(ADDR_STATUS, 8'h88);
      // a starting mode write clears ready and error
      wr(ADDR_MODE, 8'h23);
      rchk(ADDR_STATUS, 8'h00);
      // auxiliary conversion, blocking and bit clear
      pulse(1'b0, 24'h00ABCD, 1'b0, 1'b0);
      pulse(1'b0, 24'h001111, 1'b0, 1'b0);
      rchk(ADDR_STATUS, 8'h40);
      rchk(ADDR_ARES_L, 8'hCD);
      rchk(ADDR_ARES_H, 8'hAB);
      pulse(1'b0, 24'h000000, 1'b1, 1'b0);
      rchk(ADDR_STATUS, 8'h40);
      bw(8'hDE, 1'b0);
      pulse(1'b0, 24'h000000, 1'b1, 1'b0);
      rchk(ADDR_STATUS, 8'h44);
      // zero-scale calibration, auxiliary one fails
      wr(ADDR_MODE, 8'h34);
      rchk(ADDR_STATUS, 8'h00);
      pulse(1'b1, 24'h0A0B0C, 1'b0, 1'b0);
      pulse(1'b0, 24'h005555, 1'b0, 1'b1);
      rchk(ADDR_STATUS, 8'hE4);
      rchk(ADDR_POFS_L, 8'h0C);
      rchk(ADDR_POFS_H, 8'h0A);
      rchk(ADDR_AOFS_L, 8'h00);
      // full-scale calibration writes gain and clears trim at start
      wr(ADDR_MODE, 8'h35);
      rchk(ADDR_STATUS, 8'h00);
      pulse(1'b1, 24'h010203, 1'b0, 1'b0);
      pulse(1'b0, 24'h00BEEF, 1'b0, 1'b0);
      rchk(ADDR_PGAIN_L, 8'h03);
      rchk(ADDR_PGAIN_M, 8'h02);
      rchk(ADDR_AGAIN_H, 8'hBE);
      rchk(ADDR_STATUS, 8'hE0);
      // missing external reference forces ones
      wr(ADDR_MODE, 8'h33);
      i_ref_bad = 1'b1;
      i_ext_ref_sel = 1'b1;
      pulse(1'b1, 24'h000011, 1'b0, 1'b0);
      rchk(ADDR_STATUS, 8'h98);
      rchk(ADDR_PRES_L, 8'hFF);
      rchk(ADDR_PRES_H, 8'hFF);
      i_ref_bad = 1'b0;
      i_ext_ref_sel = 1'b0;
      rchk(ADDR_STATUS, 8'h88);
      // primary calibration error flags and leaves the offset untouched
      wr(ADDR_MODE, 8'h24);
      pulse(1'b1, 24'h777777, 1'b0, 1'b1);
      rchk(ADDR_STATUS, 8'hA8);
      rchk(ADDR_POFS_L, 8'h0C);
      // power-down mode write, bad reference while stopped, refused bit writes
      wr(ADDR_MODE, 8'h20);
      i_ref_bad = 1'b1;
      bw(8'hDD, 1'b0);
      bw(8'hDF, 1'b1);
      rchk(ADDR_STATUS, 8'hA8);
      i_ref_bad = 1'b0;
      // decimation ratio and a frozen clock enable
      wr(ADDR_DECIM, 8'h12);
      `CHK("decim", 8'h12, o_decim_ratio)
      i_ce = 1'b0;
      wr(ADDR_DECIM, 8'h77);
      i_ce = 1'b1;
      `CHK("decim", 8'h12, o_decim_ratio)
      // reset in mid-run returns everything to power-on values
      i_resetn = 1'b0;
      @(negedge i_clk);
      `CHK("mode", 8'h00, o_mode)
      `CHK("decim", 8'h40, o_decim_ratio)
      `CHK("rdata", 8'h00, o_sfr_rdata)
      i_resetn = 1'b1;
      rchk(ADDR_STATUS, 8'h00);
      final_report();
   end
endmodule // dual_adc_status_flag_logic_tb_top
